// [dv/dio_port_bench.sv]
// self-checking bench for the digital i/o port
`timescale 1ns/1ps
`default_nettype none
module dio_port_bench;
  import dio_pkg::*;
  localparam int TK = 10;
  localparam int SW = 4;
  logic        clk_sys, rstn, hold_wr, re_wr, re_val, re_q, ri_wr, ri_val, ri_q;
  logic [2:0]  din_pin, din_read_val, din_rise_evt, din_fall_evt, out1_src, out2_src, sen, lv;
  logic [1:0]  din_read_idx, hold_wr_idx, out_invert, dout_pin, dout_level, e;
  logic [9:0]  hold_wr_ms;
  logic [5:0]  st;
  logic        relay_closed, program_changed, transient_start, func_strobe;
  logic [31:0] rs;
  logic [7:0]  expq[$];
  int          err_total, n_checks, sn;

  dio_port #(.TICK_CYC(TK), .STROBE_CYC(SW)) uut (.clk_sys(clk_sys), .rstn(rstn), .din_pin(din_pin),
    .din_read_idx(din_read_idx), .din_read_val(din_read_val), .din_rise_evt(din_rise_evt),
    .din_fall_evt(din_fall_evt), .hold_wr(hold_wr), .hold_wr_idx(hold_wr_idx), .hold_wr_ms(hold_wr_ms),
    .out1_src(out1_src), .out2_src(out2_src), .out_invert(out_invert), .st_out_enabled(st[0]),
    .phase_indicator_a(st[1]), .st_fault(st[2]), .st_transient_active(st[3]), .st_program_steady(st[4]),
    .st_remote(st[5]), .dout_pin(dout_pin), .dout_level(dout_level), .remote_enable_wr(re_wr),
    .remote_enable_val(re_val), .remote_enable_q(re_q), .remote_inhibit_wr(ri_wr), .remote_inhibit_val(ri_val),
    .remote_inhibit_q(ri_q), .relay_change_strobe_enable(sen[0]), .program_strobe_enable(sen[1]),
    .transient_strobe_enable(sen[2]), .relay_closed(relay_closed), .program_changed(program_changed),
    .transient_start(transient_start), .func_strobe(func_strobe));
  dio_sw_model pm (.clk_sys(clk_sys), .din_pin(din_pin));

  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  function automatic logic [31:0] xs(input logic [31:0] v);
    v ^= v << 13;
    v ^= v >> 17;
    v ^= v << 5;
    return v;
  endfunction
  // expected pin level before inversion: codes 0 and 1 are fixed, the rest pick a status bit
  function automatic logic sel(input logic [2:0] s, input logic [5:0] t);
    return (s < 3'h2) ? s[0] : t[s - 3'h2];
  endfunction
  task automatic cmp(input string nm, input logic [7:0] ex, input logic [7:0] sv);
    n_checks++;
    if (sv !== ex) begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", nm, ex, sv);
    end
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // bounded wait until every noted event has been seen
  task automatic drain(input int lim);
    for (int k = 0; k < lim && expq.size() != 0; k++) @(posedge clk_sys);
    if (expq.size() != 0) begin
      cmp("event wait", 8'h00, 8'(expq.size()));
      stop_test();
    end
  endtask
  task automatic hold(input int i, input int ms);
    @(posedge clk_sys);
    hold_wr <= 1'b1;
    hold_wr_idx <= 2'(i + 1);
    hold_wr_ms <= 10'(ms);
    @(posedge clk_sys);
    hold_wr <= 1'b0;
  endtask
  // move one input, expect its event no earlier than the hold time, then read the levels back
  task automatic edge_t(input int i, input logic v, input int hms);
    expq.push_back(8'((v ? 8'h10 : 8'h20) + i));
    lv[i] = v;
    pm.put(i, v);
    if (hms > 0) begin
      repeat (hms * TK - 5) @(posedge clk_sys);
      cmp("early event", 8'h01, 8'(expq.size()));
    end
    drain(hms * TK + TK + 12);
    din_read_idx <= 2'(i + 1);
    repeat (2) @(posedge clk_sys);
    #1 cmp("read one", {7'h00, v}, {5'h00, din_read_val});
    @(posedge clk_sys);
    din_read_idx <= 2'h0;
    repeat (2) @(posedge clk_sys);
    #1 cmp("read all", {5'h00, lv}, {5'h00, din_read_val});
  endtask
  task automatic strb(input logic [2:0] en, input logic [2:0] c, input bit ex, input bit again);
    @(posedge clk_sys);
    sen <= en;
    if (ex) expq.push_back(8'h30);
    @(posedge clk_sys);
    relay_closed <= relay_closed ^ c[0];
    program_changed <= c[1];
    transient_start <= c[2];
    @(posedge clk_sys);
    program_changed <= 1'b0;
    transient_start <= again;
    @(posedge clk_sys);
    transient_start <= 1'b0;
    repeat (SW + 6) @(posedge clk_sys);
    cmp("strobe pending", 8'h00, 8'(expq.size()));
  endtask

  // monitor: each event or strobe start takes the oldest note; a strobe's width is counted
  always @(posedge clk_sys) begin
    if (rstn) begin
      for (int i = 0; i < 3; i++) begin
        if (din_rise_evt[i] !== 1'b0) cmp("event", expq.size() ? expq.pop_front() : 8'hff, 8'(8'h10 + i));
        if (din_fall_evt[i] !== 1'b0) cmp("event", expq.size() ? expq.pop_front() : 8'hff, 8'(8'h20 + i));
      end
      if (func_strobe !== 1'b0 && sn == 0) cmp("event", expq.size() ? expq.pop_front() : 8'hff, 8'h30);
      if (func_strobe !== 1'b0) sn++;
      else if (sn != 0) begin
        cmp("strobe width", 8'(SW), 8'(sn));
        sn = 0;
      end
    end
  end

  initial begin
    {rstn, hold_wr, re_wr, re_val, ri_wr, ri_val, relay_closed, program_changed, transient_start} = '0;
    {din_read_idx, hold_wr_idx, out_invert, hold_wr_ms, out1_src, out2_src, st, sen, lv} = '0;
    rs = 32'hcd102cdb;
    err_total = 0;
    n_checks = 0;
    sn = 0;
    repeat (10) @(posedge clk_sys);
    rstn <= 1'b1;
    @(posedge clk_sys);
    #1 cmp("remote after reset", 8'h00, {6'h00, re_q, ri_q});
    // every source code on both outputs, both polarities, random status levels
    for (int n = 0; n < 32; n++) begin
      rs = xs(rs);
      @(posedge clk_sys);
      out1_src <= 3'(n);
      out2_src <= 3'(7 - n);
      out_invert <= 2'(n >> 3);
      st <= rs[5:0];
      repeat (2) @(posedge clk_sys);
      e = {sel(3'(7 - n), rs[5:0]), sel(3'(n), rs[5:0])} ^ 2'(n >> 3);
      #1 cmp("dout pin", {6'h00, e}, {6'h00, dout_pin});
      cmp("dout level", {6'h00, e}, {6'h00, dout_level});
    end
    $display("test outputs done");
    hold(-1, 5); // index zero write is ignored
    edge_t(0, 1'b1, 0);
    expq.push_back(8'h20);
    expq.push_back(8'h10);
    pm.blip(0, 3);
    drain(30);
    hold(1, 2);
    pm.blip(1, 12);
    repeat (40) @(posedge clk_sys);
    edge_t(1, 1'b1, 2);
    edge_t(1, 1'b0, 2);
    hold(2, 1023);
    edge_t(2, 1'b1, 1000);
    $display("test inputs done");
    for (int n = 0; n < 4; n++) begin
      @(posedge clk_sys);
      re_wr <= 1'b1;
      re_val <= n[0];
      @(posedge clk_sys);
      re_wr <= 1'b0;
      ri_wr <= 1'b1;
      ri_val <= n[1];
      @(posedge clk_sys);
      ri_wr <= 1'b0;
      @(posedge clk_sys);
      #1 cmp("remote states", 8'(n), {6'h00, ri_q, re_q});
    end
    $display("test remote done");
    for (int k = 0; k < 3; k++) begin
      strb(3'(1 << k), 3'(1 << k), 1'b1, 1'b0);
      strb(~3'(1 << k), 3'(1 << k), 1'b0, 1'b0);
    end
    strb(3'h7, 3'h7, 1'b1, 1'b1);
    $display("test strobe done");
    stop_test();
  end
endmodule // dio_port_bench
`default_nettype wire

// [dv/dio_sw_model.sv]
// external switch model that drives the digital input pins
`timescale 1ns/1ps
`default_nettype none
module dio_sw_model
  import dio_pkg::*;
(
  input  wire logic                  clk_sys,
  output logic [DIO_NUM_IN-1:0]      din_pin
);
  initial din_pin = '0;
  // a contact moves just after an edge and then stays put
  task automatic put(input int i, input logic v);
    @(posedge clk_sys);
    din_pin[i] <= v;
  endtask
  // contact bounce: a short excursion that a long hold time has to swallow
  task automatic blip(input int i, input int n);
    put(i, !din_pin[i]);
    repeat (n) @(posedge clk_sys);
    din_pin[i] <= !din_pin[i];
  endtask
endmodule // dio_sw_model
`default_nettype wire

// [rtl/dio_pkg.sv]
// package: constants and types for the digital i/o port logic
package dio_pkg;
  localparam int unsigned DIO_NUM_IN       = 3;        // digital inputs
  localparam int unsigned DIO_NUM_OUT      = 2;        // digital outputs
  localparam int unsigned DIO_HOLD_MAX_MS  = 1000;     // largest hold time
  localparam int unsigned DIO_HOLD_W       = 10;       // bits for 0..1000
  localparam logic [9:0]  DIO_HOLD_RST     = 10'h000;  // hold time after reset
  localparam int unsigned DIO_CLK_HZ       = 100000000;
  localparam int unsigned DIO_TICK_NS      = 1000000;  // 1 ms time base
  localparam int unsigned DIO_CLK_NS       = 10;
  localparam int unsigned DIO_TICK_CYC     = DIO_TICK_NS / DIO_CLK_NS;
  localparam int unsigned DIO_STROBE_CYC   = 100;      // strobe pulse width
  localparam int unsigned DIO_SEL_W        = 3;
  localparam int unsigned DIO_IDX_W        = 2;        // 0 = all inputs on readback; a hold write to index 0 is ignored

  // output source selection
  typedef enum logic [2:0] {
    DIO_SRC_LOW       = 3'h0,
    DIO_SRC_HIGH      = 3'h1,
    DIO_SRC_OUT_STATE = 3'h2,
    DIO_SRC_PHASE_INDICATOR_A      = 3'h3,
    DIO_SRC_FAULT     = 3'h4,
    DIO_SRC_TRANSIENT = 3'h5,
    DIO_SRC_PROGRAM   = 3'h6,
    DIO_SRC_REMOTE    = 3'h7
  } dio_src_e;

  localparam dio_src_e DIO_SRC1_RST = DIO_SRC_OUT_STATE;
  localparam dio_src_e DIO_SRC2_RST = DIO_SRC_PHASE_INDICATOR_A;

  // input filter states, gray coded
  typedef enum logic [1:0] {
    DIO_FLT_IDLE = 2'b00,
    DIO_FLT_WAIT = 2'b01
  } dio_flt_e;
endpackage : dio_pkg

// [rtl/dio_port.sv]
// digital i/o port: filtered inputs with edge events, source-selected outputs, remote states, strobe
`timescale 1ns/1ps
`default_nettype none
module dio_port
  import dio_pkg::*;
#(
  parameter int unsigned TICK_CYC   = DIO_TICK_CYC,
  parameter int unsigned STROBE_CYC = DIO_STROBE_CYC
) (
  input  wire logic                  clk_sys,
  input  wire logic                  rstn,
  input  wire logic [DIO_NUM_IN-1:0] din_pin,
  input  wire logic [DIO_IDX_W-1:0]  din_read_idx,
  output logic [DIO_NUM_IN-1:0]      din_read_val,
  output logic [DIO_NUM_IN-1:0]      din_rise_evt,
  output logic [DIO_NUM_IN-1:0]      din_fall_evt,
  input  wire logic                  hold_wr,
  input  wire logic [DIO_IDX_W-1:0]  hold_wr_idx,
  input  wire logic [DIO_HOLD_W-1:0] hold_wr_ms,
  input  wire logic [DIO_SEL_W-1:0]  out1_src,
  input  wire logic [DIO_SEL_W-1:0]  out2_src,
  input  wire logic [DIO_NUM_OUT-1:0] out_invert,
  input  wire logic                  st_out_enabled,
  input  wire logic                  phase_indicator_a,
  input  wire logic                  st_fault,
  input  wire logic                  st_transient_active,
  input  wire logic                  st_program_steady,
  input  wire logic                  st_remote,
  output logic [DIO_NUM_OUT-1:0]     dout_pin,
  output logic [DIO_NUM_OUT-1:0]     dout_level,
  input  wire logic                  remote_enable_wr,
  input  wire logic                  remote_enable_val,
  output logic                       remote_enable_q,
  input  wire logic                  remote_inhibit_wr,
  input  wire logic                  remote_inhibit_val,
  output logic                       remote_inhibit_q,
  input  wire logic                  relay_change_strobe_enable,
  input  wire logic                  program_strobe_enable,
  input  wire logic                  transient_strobe_enable,
  input  wire logic                  relay_closed,
  input  wire logic                  program_changed,
  input  wire logic                  transient_start,
  output logic                       func_strobe
);

  localparam int unsigned TICK_W = $clog2(TICK_CYC + 1);
  localparam int unsigned STB_W  = $clog2(STROBE_CYC + 1);
  localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(TICK_CYC - 1);
  localparam logic [STB_W-1:0]  STB_LOAD  = STB_W'(STROBE_CYC);
  localparam logic [DIO_HOLD_W-1:0] HOLD_MAX = DIO_HOLD_W'(DIO_HOLD_MAX_MS);

  // two-flop synchronisers for the pins; sync1 feeds only sync2
  logic [DIO_NUM_IN-1:0] sync1_q;
  logic [DIO_NUM_IN-1:0] sync2_q;
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      sync1_q <= '0;
      sync2_q <= '0;
    end else begin
      sync1_q <= din_pin;
      sync2_q <= sync1_q;
    end
  end

  // 1 ms time base shared by all filters
  logic [TICK_W-1:0] tick_cnt_q;
  logic              tick_q;
  wire               tick_wrap = (tick_cnt_q == TICK_LAST);
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      tick_cnt_q <= '0;
      tick_q     <= 1'b0;
    end else begin
      tick_cnt_q <= tick_wrap ? '0 : tick_cnt_q + 1'b1;
      tick_q     <= tick_wrap;
    end
  end

  // per-input hold time; out-of-range writes clamp to the maximum
  logic [DIO_HOLD_W-1:0] hold_ms_q [DIO_NUM_IN];
  wire  [DIO_HOLD_W-1:0] hold_clamped = (hold_wr_ms > HOLD_MAX) ? HOLD_MAX : hold_wr_ms;

  // stable level, filter state and elapsed count per input
  logic [DIO_NUM_IN-1:0] stable_q;
  dio_flt_e              flt_q [DIO_NUM_IN];
  logic [DIO_HOLD_W-1:0] elap_q [DIO_NUM_IN];

  genvar gi;
  generate
    for (gi = 0; gi < DIO_NUM_IN; gi++) begin : g_in
      wire hold_sel  = hold_wr && (hold_wr_idx == DIO_IDX_W'(gi + 1));
      wire differs   = (sync2_q[gi] != stable_q[gi]);
      wire no_hold   = (hold_ms_q[gi] == '0);
      // the first tick may come one cycle into the wait, so one extra tick guarantees the full hold
      wire elap_done = tick_q && (elap_q[gi] >= hold_ms_q[gi]);
      // accept new level when held long enough or filter is off
      wire accept    = differs && (no_hold || (flt_q[gi] == DIO_FLT_WAIT && elap_done));

      always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
          hold_ms_q[gi] <= DIO_HOLD_RST;
        end else if (hold_sel) begin
          hold_ms_q[gi] <= hold_clamped;
        end
      end

      // filter: a bounce back to the stable level restarts the wait
      always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
          flt_q[gi]  <= DIO_FLT_IDLE;
          elap_q[gi] <= '0;
        end else if (!differs || accept) begin
          flt_q[gi]  <= DIO_FLT_IDLE;
          elap_q[gi] <= '0;
        end else begin
          flt_q[gi]  <= DIO_FLT_WAIT;
          if (flt_q[gi] == DIO_FLT_WAIT && tick_q) begin
            elap_q[gi] <= elap_q[gi] + 1'b1;
          end
        end
      end

      // edge events, one cycle each, after filtering
      always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
          stable_q[gi]     <= 1'b0;
          din_rise_evt[gi] <= 1'b0;
          din_fall_evt[gi] <= 1'b0;
        end else begin
          if (accept) stable_q[gi] <= sync2_q[gi];
          din_rise_evt[gi] <= accept && sync2_q[gi];
          din_fall_evt[gi] <= accept && !sync2_q[gi];
        end
      end

      // per-input checks on hold time and filtering
      chk_hold_clamp: assert property (@(posedge clk_sys) disable iff (!rstn)
        (hold_sel && hold_wr_ms > HOLD_MAX) |=> hold_ms_q[gi] == HOLD_MAX)
        else $error("hold time not clamped");
      chk_hold_store: assert property (@(posedge clk_sys) disable iff (!rstn)
        (hold_sel && hold_wr_ms <= HOLD_MAX) |=> hold_ms_q[gi] == $past(hold_wr_ms))
        else $error("hold time not stored");
      chk_edge_single: assert property (@(posedge clk_sys) disable iff (!rstn)
        !(din_rise_evt[gi] && din_fall_evt[gi]))
        else $error("rise and fall in one cycle");
      chk_hold_defer: assert property (@(posedge clk_sys) disable iff (!rstn)
        (hold_ms_q[gi] != '0 && flt_q[gi] == DIO_FLT_IDLE && differs) |=> !(din_rise_evt[gi] || din_fall_evt[gi]))
        else $error("filtered edge raised without waiting");
      chk_bounce_restart: assert property (@(posedge clk_sys) disable iff (!rstn)
        (flt_q[gi] == DIO_FLT_WAIT && !differs) |=> elap_q[gi] == '0)
        else $error("bounce did not restart the hold count");
    end
  endgenerate

  // input readback: index 0 returns all, 1..3 one level in bit 0
  wire [DIO_NUM_IN-1:0] rd_one = {{(DIO_NUM_IN-1){1'b0}}, stable_q[din_read_idx - 2'h1]};
  wire                  rd_all = (din_read_idx == '0) || (din_read_idx > DIO_IDX_W'(DIO_NUM_IN));
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) din_read_val <= '0;
    else       din_read_val <= rd_all ? stable_q : rd_one;
  end

  // output source selection, then polarity
  function automatic logic pick_src(input logic [DIO_SEL_W-1:0] sel, input logic [5:0] st);
    logic r;
    r = 1'b0;
    unique case (dio_src_e'(sel))
      DIO_SRC_LOW:       r = 1'b0;
      DIO_SRC_HIGH:      r = 1'b1;
      DIO_SRC_OUT_STATE: r = st[0];
      DIO_SRC_PHASE_INDICATOR_A:      r = st[1];
      DIO_SRC_FAULT:     r = st[2];
      DIO_SRC_TRANSIENT: r = st[3];
      DIO_SRC_PROGRAM:   r = st[4];
      DIO_SRC_REMOTE:    r = st[5];
    endcase
    return r;
  endfunction

  wire [5:0] st_vec = {st_remote, st_program_steady, st_transient_active,
                       st_fault, phase_indicator_a, st_out_enabled};
  wire [DIO_NUM_OUT-1:0] src_lvl = {pick_src(out2_src, st_vec), pick_src(out1_src, st_vec)};
  wire [DIO_NUM_OUT-1:0] pin_d   = src_lvl ^ out_invert;

  // pin and its readback come from the same value, so they always agree
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      dout_pin   <= '0;
      dout_level <= '0;
    end else begin
      dout_pin   <= pin_d;
      dout_level <= pin_d;
    end
  end

  // remote enable and inhibit are independent latches
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      remote_enable_q  <= 1'b0;
      remote_inhibit_q <= 1'b0;
    end else begin
      if (remote_enable_wr)  remote_enable_q  <= remote_enable_val;
      if (remote_inhibit_wr) remote_inhibit_q <= remote_inhibit_val;
    end
  end

  // strobe causes; relay state is registered to see its changes
  logic relay_q;
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) relay_q <= 1'b0;
    else       relay_q <= relay_closed;
  end
  wire relay_trig = relay_change_strobe_enable && (relay_closed != relay_q);
  wire prog_trig  = program_strobe_enable && program_changed;
  wire tran_trig  = transient_strobe_enable && transient_start;
  wire any_trig   = relay_trig || prog_trig || tran_trig;

  // one pulse; a cause arriving mid-pulse is absorbed so width stays fixed
  logic [STB_W-1:0] stb_cnt_q;
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      stb_cnt_q   <= '0;
      func_strobe <= 1'b0;
    end else if (stb_cnt_q != '0) begin
      stb_cnt_q   <= stb_cnt_q - 1'b1;
      func_strobe <= (stb_cnt_q != STB_W'(1));
    end else if (any_trig) begin
      stb_cnt_q   <= STB_LOAD;
      func_strobe <= 1'b1;
    end
  end

  // checks on the input path and the time base
  chk_hold_range: assert property (@(posedge clk_sys) disable iff (!rstn)
    hold_ms_q[0] <= HOLD_MAX) else $error("hold time above maximum");
  chk_rise_level: assert property (@(posedge clk_sys) disable iff (!rstn)
    din_rise_evt[0] |-> stable_q[0]) else $error("rise event with low level");
  chk_fall_level: assert property (@(posedge clk_sys) disable iff (!rstn)
    din_fall_evt[1] |-> !stable_q[1]) else $error("fall event with high level");
  chk_zero_hold: assert property (@(posedge clk_sys) disable iff (!rstn)
    (hold_ms_q[0] == '0 && sync2_q[0] != stable_q[0]) |=> (din_rise_evt[0] || din_fall_evt[0]))
    else $error("unfiltered edge not immediate");
  chk_filter_wait: assert property (@(posedge clk_sys) disable iff (!rstn)
    (hold_ms_q[2] != '0 && $stable(hold_ms_q[2]) && $changed(stable_q[2])) |-> $past(flt_q[2]) == DIO_FLT_WAIT)
    else $error("filtered edge accepted without waiting");
  chk_tick_period: assert property (@(posedge clk_sys) disable iff (!rstn)
    tick_q |=> !tick_q) else $error("tick longer than one cycle");
  chk_tick_gap: assert property (@(posedge clk_sys) disable iff (!rstn)
    tick_q |-> tick_cnt_q == '0)
    else $error("tick out of step with its counter");

  // output path: source, polarity and readback
  chk_out_invert: assert property (@(posedge clk_sys) disable iff (!rstn)
    $past(out_invert[0]) && $past(dio_src_e'(out1_src)) == DIO_SRC_HIGH |-> !dout_pin[0])
    else $error("inverted high did not drive low");
  chk_out_fault: assert property (@(posedge clk_sys) disable iff (!rstn)
    ($past(dio_src_e'(out2_src)) == DIO_SRC_FAULT && !$past(out_invert[1])) |-> dout_pin[1] == $past(st_fault))
    else $error("fault source mismatch");
  chk_out_high: assert property (@(posedge clk_sys) disable iff (!rstn)
    ($past(dio_src_e'(out1_src)) == DIO_SRC_HIGH && !$past(out_invert[0])) |-> dout_pin[0])
    else $error("fixed high did not drive high");
  chk_out_enabled: assert property (@(posedge clk_sys) disable iff (!rstn)
    ($past(dio_src_e'(out1_src)) == DIO_SRC_OUT_STATE && !$past(out_invert[0])) |-> dout_pin[0] == $past(st_out_enabled))
    else $error("output enabled source mismatch");
  chk_out_remote: assert property (@(posedge clk_sys) disable iff (!rstn)
    ($past(dio_src_e'(out2_src)) == DIO_SRC_REMOTE && !$past(out_invert[1])) |-> dout_pin[1] == $past(st_remote))
    else $error("remote source mismatch");
  chk_readback: assert property (@(posedge clk_sys) disable iff (!rstn)
    dout_level == dout_pin) else $error("readback differs from pin");
  chk_level_inv: assert property (@(posedge clk_sys) disable iff (!rstn)
    ($past(dio_src_e'(out2_src)) == DIO_SRC_LOW) |-> dout_level[1] == $past(out_invert[1]))
    else $error("readback not taken after inversion");

  // input level readback
  chk_read_all: assert property (@(posedge clk_sys) disable iff (!rstn)
    (din_read_idx == '0) |=> din_read_val == $past(stable_q))
    else $error("read all returned wrong levels");
  chk_read_one: assert property (@(posedge clk_sys) disable iff (!rstn)
    (din_read_idx == DIO_IDX_W'(1)) |=> din_read_val == {{(DIO_NUM_IN-1){1'b0}}, $past(stable_q[0])})
    else $error("read one returned wrong level");

  // remote states
  chk_remote_en: assert property (@(posedge clk_sys) disable iff (!rstn)
    remote_enable_wr |=> remote_enable_q == $past(remote_enable_val))
    else $error("remote enable not stored");
  chk_remote_inh: assert property (@(posedge clk_sys) disable iff (!rstn)
    remote_inhibit_wr |=> remote_inhibit_q == $past(remote_inhibit_val))
    else $error("remote inhibit not stored");
  chk_remote_hold: assert property (@(posedge clk_sys) disable iff (!rstn)
    (!remote_enable_wr && !remote_inhibit_wr) |=> ($stable(remote_enable_q) && $stable(remote_inhibit_q)))
    else $error("remote state changed without a write");

  // strobe: each enabled cause starts a pulse when none is running
  chk_strobe_start: assert property (@(posedge clk_sys) disable iff (!rstn)
    (any_trig && !func_strobe && stb_cnt_q == '0) |=> func_strobe [*2])
    else $error("strobe did not start");
  chk_relay_strobe: assert property (@(posedge clk_sys) disable iff (!rstn)
    (relay_trig && stb_cnt_q == '0) |=> func_strobe)
    else $error("relay change gave no strobe");
  chk_prog_strobe: assert property (@(posedge clk_sys) disable iff (!rstn)
    (prog_trig && stb_cnt_q == '0) |=> func_strobe)
    else $error("program change gave no strobe");
  chk_tran_strobe: assert property (@(posedge clk_sys) disable iff (!rstn)
    (tran_trig && stb_cnt_q == '0) |=> func_strobe)
    else $error("transient start gave no strobe");
  chk_strobe_quiet: assert property (@(posedge clk_sys) disable iff (!rstn)
    (!any_trig && stb_cnt_q == '0) |=> !func_strobe)
    else $error("strobe without an enabled cause");

  // helper for the width check: length of the running strobe pulse
  logic [STB_W-1:0] stb_len_q;
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) stb_len_q <= '0;
    else       stb_len_q <= func_strobe ? stb_len_q + 1'b1 : '0;
  end
  chk_strobe_width: assert property (@(posedge clk_sys) disable iff (!rstn)
    $fell(func_strobe) |-> stb_len_q == STB_LOAD)
    else $error("strobe width wrong");

  cov_rise: cover property (@(posedge clk_sys) disable iff (!rstn) din_rise_evt[0]);
  cov_fall_filtered: cover property (@(posedge clk_sys) disable iff (!rstn) din_fall_evt[1] && hold_ms_q[1] != '0);
  cov_strobe_relay: cover property (@(posedge clk_sys) disable iff (!rstn) relay_trig && !func_strobe);
  cov_strobe_merge: cover property (@(posedge clk_sys) disable iff (!rstn) prog_trig && tran_trig);
  cov_hold_clamp: cover property (@(posedge clk_sys) disable iff (!rstn) hold_wr && hold_wr_ms > HOLD_MAX);

endmodule // dio_port
`default_nettype wire
